// ==== rtl/gpp_pkg.sv ====
// Constants and types shared by the general purpose port
`default_nettype none
package gpp_pkg;
  localparam int GPP_W = 16;
  localparam int GPP_HALF = 8;
  localparam int GPP_AW = 8;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_VEC = 8'h0c;
  localparam logic [7:0] OFS_SET = 8'h10;
  localparam logic [7:0] OFS_CLR = 8'h14;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CFG_DMA_POS = 0;
  localparam int CFG_SER_POS = 1;
  localparam int CFG_CMB_POS = 2;
  localparam int CFG_IRQ_POS = 3;
  localparam int ACK_TX_A = 0;
  localparam int ACK_RX_A = 1;
  localparam int ACK_TX_B = 2;
  localparam int ACK_RX_B = 3;
  localparam logic [15:0] RST_DATA = 16'hffff;
  localparam logic [15:0] RST_DIR = 16'h0000;
  localparam logic [3:0] RST_CFG = 4'h0;
  // Arbitrary tag marking a port vector
  localparam logic [7:0] VEC_TAG = 8'h5a;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic port_irq_enable;
    logic combine_ack_pins;
    logic serial_pin_select;
    logic dma_pin_select;
  } gpp_cfg_t;
  typedef struct packed {
    logic [7:0] tag;
    logic [5:0] rsvd;
    logic [1:0] src;
  } gpp_vec_t;
  typedef enum logic {
    GPP_WR_IDLE = 1'b0,
    GPP_WR_RESP = 1'b1
  } gpp_wr_t;
endpackage
`default_nettype wire

// ==== rtl/gpp_sync.sv ====
// Three-stage pin synchroniser feeding the input latch
`default_nettype none
module gpp_sync import gpp_pkg::*; #(
  parameter int W = GPP_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin_i,
  output var logic [W-1:0] level_q
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  logic [W-1:0] agree;
  // Stage one feeds stage two only; agreement uses stages two and three
  assign agree = ~(s2_q ^ s3_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= (agree & s3_q) | (~agree & level_q); // [RQ7] [RQ21]
    end
  end
endmodule
`default_nettype wire

// ==== rtl/gpp_port.sv ====
// General purpose port: 16 pins, AXI4-Lite registers, alternate functions
//
// Function
// RQ1: Sixteen-bit port as two eight-bit halves, each selectable GPIO or alternate.
// RQ2: Dma pin select turns the low half into DMA support pins.
// RQ3: Serial pin select turns the high half into serial controller pins.
// RQ4: With DMA selected, combine bit merges tx and rx acknowledge per channel.
// RQ5: Each line's direction comes from its pin direction register bit.
// RQ6: Input lines float; output lines drive both high and low.
// RQ7: Every pin level is sampled into the input latch each state time; the latch only takes a level once stages two and three agree.
// RQ8: Input line: write updates output latch, read returns input latch.
// RQ9: Input line read-modify-write uses the pin value, stores into output latch.
// RQ10: Output line: write updates latch and pin, read returns the latch.
// RQ11: Output line read-modify-write uses latch value, writes back to latch.
// RQ12: Alternate output reaches pin only as output, ANDed with the latch.
// RQ13: Software keeps a line input while an outside device drives it.
// RQ14: Reset clears all direction bits, so every line starts as input.
// RQ15: Alternate input on an output line sees the output latch value.
// RQ16: Lines not claimed by an alternate function stay ordinary GPIO.
// RQ17: Software should load the latch before switching a line to output.
// RQ18: A peripheral interrupt on the port produces a port vector.
// RQ19: Port vectors are produced only while the port interrupt enable is set.
// RQ20: Reset returns alternate pins to GPIO and all registers to reset values.
// RQ21: One state time is one clock; pins are synchronised on that clock.
`default_nettype none
module gpp_port import gpp_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] pin_i,
  output logic [15:0] pin_o,
  output logic [15:0] pin_oe,
  input wire logic [15:0] alt_out,
  output logic [15:0] alt_in,
  input wire logic [1:0] irq_req,
  output logic vec_valid,
  output gpp_vec_t vec_data
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [15:0] wr_mask(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0] = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction
  function automatic logic [15:0] by_dir(input logic [15:0] dir, input logic [15:0] outv, input logic [15:0] inv);
    return (dir & outv) | (~dir & inv);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [15:0] out_q, dir_q, in_q;
  gpp_cfg_t cfg_q;
  gpp_vec_t last_vec_q;
  logic [15:0] pin_o_q, pin_oe_q, alt_in_q;
  logic vec_valid_q;
  gpp_vec_t vec_data_q;
  logic aw_held_q, w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  gpp_wr_t wr_st_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  gpp_sync #(.W(GPP_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_i(pin_i),
    .level_q(in_q)
  );

  // ****************************************
  // Pin function selection
  // ****************************************
  wire logic [15:0] port_view = by_dir(dir_q, out_q, in_q); // [RQ8] [RQ10]
  wire logic cmb = cfg_q.dma_pin_select & cfg_q.combine_ack_pins;
  wire logic [7:0] lo_mask = {8{cfg_q.dma_pin_select}} & ~({7'h0, cmb} << ACK_RX_A)
                             & ~({7'h0, cmb} << ACK_RX_B); // [RQ2] [RQ4] [RQ16]
  wire logic [7:0] hi_mask = {8{cfg_q.serial_pin_select}}; // [RQ3]
  wire logic [15:0] alt_mask = {hi_mask, lo_mask}; // [RQ1]
  // Merged acks are active low, so AND keeps either request visible
  wire logic ack_a = alt_out[ACK_TX_A] & alt_out[ACK_RX_A];
  wire logic ack_b = alt_out[ACK_TX_B] & alt_out[ACK_RX_B];
  wire logic [15:0] alt_eff = cmb ? {alt_out[15:3], ack_b, alt_out[1], ack_a} : alt_out; // [RQ4]
  wire logic [15:0] pin_d = alt_mask & out_q & alt_eff | ~alt_mask & out_q; // [RQ12]
  wire logic [15:0] alt_in_d = alt_mask & port_view; // [RQ15]

  // ****************************************
  // AXI write path
  // ****************************************
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic aw_have = aw_held_q | aw_take;
  wire logic w_have = w_held_q | w_take;
  wire logic [7:0] wa = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire logic [31:0] wd = w_held_q ? w_data_q : s_axi_wdata;
  wire logic [3:0] ws = w_held_q ? w_strb_q : s_axi_wstrb;
  wire logic do_wr = aw_have & w_have & (wr_st_q == GPP_WR_IDLE);
  wire logic wa_ok = wa inside {OFS_DATA, OFS_DIR, OFS_CFG, OFS_VEC, OFS_SET, OFS_CLR};
  // Set/clear registers are hardware read-modify-write on the port view
  wire logic [15:0] rmw_set = port_view | wd[15:0]; // [RQ9] [RQ11]
  wire logic [15:0] rmw_clr = port_view & ~wd[15:0]; // [RQ9] [RQ11]
  wire logic [15:0] out_d = !do_wr ? out_q :
                            wa == OFS_DATA ? wr_mask(out_q, wd, ws) : // [RQ8] [RQ10]
                            wa == OFS_SET ? wr_mask(out_q, {16'h0000, rmw_set}, ws) :
                            wa == OFS_CLR ? wr_mask(out_q, {16'h0000, rmw_clr}, ws) : out_q;
  wire logic [15:0] dir_d = (do_wr & wa == OFS_DIR) ? wr_mask(dir_q, wd, ws) : dir_q; // [RQ5]
  wire gpp_cfg_t cfg_d = (do_wr & wa == OFS_CFG & ws[0]) ? gpp_cfg_t'(wd[3:0]) : cfg_q;
  assign s_axi_awready = ~aw_held_q & (wr_st_q == GPP_WR_IDLE);
  assign s_axi_wready = ~w_held_q & (wr_st_q == GPP_WR_IDLE);
  assign s_axi_bvalid = (wr_st_q == GPP_WR_RESP);
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      wr_st_q <= GPP_WR_IDLE;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) aw_addr_q <= s_axi_awaddr;
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      aw_held_q <= aw_have & ~do_wr;
      w_held_q <= w_have & ~do_wr;
      unique case (wr_st_q)
        GPP_WR_IDLE: if (do_wr) begin
          wr_st_q <= GPP_WR_RESP;
          bresp_q <= wa_ok ? RESP_OKAY : RESP_SLVERR;
        end
        GPP_WR_RESP: if (s_axi_bready) wr_st_q <= GPP_WR_IDLE;
      endcase
    end
  end

  // ****************************************
  // AXI read path
  // ****************************************
  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  wire logic [31:0] rd_mux = s_axi_araddr == OFS_DATA ? {16'h0000, port_view} : // [RQ8] [RQ10]
                             s_axi_araddr == OFS_DIR ? {16'h0000, dir_q} :
                             s_axi_araddr == OFS_CFG ? {28'h0000000, cfg_q} :
                             s_axi_araddr == OFS_VEC ? {16'h0000, last_vec_q} : 32'h0000_0000;
  wire logic ra_ok = s_axi_araddr inside {OFS_DATA, OFS_DIR, OFS_CFG, OFS_VEC, OFS_SET, OFS_CLR};
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= ra_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Port registers, pins and vector
  // ****************************************
  wire logic vec_fire = cfg_q.port_irq_enable & (|irq_req); // [RQ18] [RQ19]
  wire gpp_vec_t vec_d = '{tag: VEC_TAG, rsvd: 6'h00, src: irq_req};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= RST_DATA;
      dir_q <= RST_DIR; // [RQ14] [RQ20]
      cfg_q <= gpp_cfg_t'(RST_CFG); // [RQ20]
      pin_o_q <= RST_DATA;
      pin_oe_q <= RST_DIR; // [RQ6]
      alt_in_q <= 16'h0000;
      vec_valid_q <= 1'b0;
      vec_data_q <= '0;
      last_vec_q <= '0;
    end else begin
      out_q <= out_d;
      dir_q <= dir_d;
      cfg_q <= cfg_d;
      pin_o_q <= pin_d;
      pin_oe_q <= dir_q; // [RQ6]
      alt_in_q <= alt_in_d;
      vec_valid_q <= vec_fire;
      if (vec_fire) begin
        vec_data_q <= vec_d;
        last_vec_q <= vec_d;
      end
    end
  end
  // Pins lag the registers by one clock; the bench joins pin_o by pin_oe
  assign pin_o = pin_o_q;
  assign pin_oe = pin_oe_q;
  assign alt_in = alt_in_q;
  assign vec_valid = vec_valid_q;
  assign vec_data = vec_data_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_dir_reset;
    $past(!aresetn) |-> dir_q == 16'h0000 && cfg_q == gpp_cfg_t'(RST_CFG);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared by reset"); // [RQ14] [RQ20]

  property p_oe_dir;
    ##1 pin_oe == $past(dir_q);
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin enable does not follow direction"); // [RQ5] [RQ6]

  property p_gpio_pin;
    ##1 ((pin_o ^ $past(out_q)) & ~$past(alt_mask)) == 16'h0000;
  endproperty
  a_gpio_pin: assert property (p_gpio_pin) else $error("gpio pin differs from latch"); // [RQ10] [RQ16]

  property p_alt_and;
    ##1 (pin_o & $past(alt_mask) & ~($past(out_q) & $past(alt_eff))) == 16'h0000;
  endproperty
  a_alt_and: assert property (p_alt_and) else $error("alternate output not gated by latch"); // [RQ12]

  property p_read_data;
    ar_take && s_axi_araddr == OFS_DATA |=> s_axi_rvalid
      && s_axi_rdata[15:0] == by_dir($past(dir_q), $past(out_q), $past(in_q));
  endproperty
  a_read_data: assert property (p_read_data) else $error("data read not by direction"); // [RQ8] [RQ10]

  property p_vec_on;
    (|irq_req) && cfg_q.port_irq_enable |=> vec_valid && vec_data.src == $past(irq_req);
  endproperty
  a_vec_on: assert property (p_vec_on) else $error("port vector missing"); // [RQ18]

  property p_vec_off;
    !cfg_q.port_irq_enable |=> !vec_valid;
  endproperty
  a_vec_off: assert property (p_vec_off) else $error("vector while disabled"); // [RQ19]

  property p_combine;
    cfg_q.dma_pin_select && cfg_q.combine_ack_pins |-> !alt_mask[ACK_RX_A] && !alt_mask[ACK_RX_B]
      && alt_mask[ACK_TX_A];
  endproperty
  a_combine: assert property (p_combine) else $error("ack pins not combined"); // [RQ4]

  property p_loop;
    ##1 (alt_in & ~$past(alt_mask)) == 16'h0000
      && (alt_in & $past(dir_q)) == ($past(out_q) & $past(dir_q) & $past(alt_mask));
  endproperty
  a_loop: assert property (p_loop) else $error("alternate input loopback wrong"); // [RQ15]

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

  property p_set;
    do_wr && wa == OFS_SET && ws[1:0] == 2'h3 |=> out_q == ($past(port_view) | 16'($past(wd)));
  endproperty
  a_set: assert property (p_set) else $error("set register did not merge into latch"); // [RQ9] [RQ11]

  property p_clr;
    do_wr && wa == OFS_CLR && ws[1:0] == 2'h3 |=> out_q == ($past(port_view) & ~16'($past(wd)));
  endproperty
  a_clr: assert property (p_clr) else $error("clear register did not merge into latch"); // [RQ9] [RQ11]

  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
endmodule
`default_nettype wire

// ==== test/gpp_pins_model.sv ====
// Pin-side model: an outside device driving the port lines
`default_nettype none
module gpp_pins_model (
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext_val,
  output logic [15:0] pin_i
);
  // Outside device drives only lines left as inputs
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

// ==== test/gpp_tb.sv ====
// Self-checking bench for the general purpose port
`default_nettype none
module testbench import gpp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic bvalid, rvalid, awready, wready, arready, vec_valid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, c;
  logic [1:0] bresp, rresp, irq_req;
  logic [15:0] pin_i, pin_o, pin_oe, alt, alt_in, ext, lat, dir, m;
  gpp_vec_t vec_data;
  logic [3:0] cl [4] = '{4'h1, 4'h2, 4'h5, 4'h6};
  int n_mismatch, n_checks, k;
  gpp_port gpp_port_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .alt_out(alt), .alt_in(alt_in), .irq_req(irq_req), .vec_valid(vec_valid),
    .vec_data(vec_data));
  gpp_pins_model gpp_pins_model_i (.pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext), .pin_i(pin_i));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo;
    n_mismatch++;
    $display("[ERR] t=%0t got=%h exp=%h (no answer)", $time, 1'b0, 1'b1);
    test_done();
  endtask
  // ****************************************
  // Bus cycles: each channel released only at its own handshake edge
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, gb;
    int i;
    gb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40 && !gb; i++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      gb = bvalid;
      if (gb) chk(bresp, er);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!gb) tmo();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, g;
    int i;
    g = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40 && !g; i++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      g = rvalid;
      if (g) begin
        chk(rdata, e);
        chk(rresp, er);
      end
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!g) tmo();
  endtask
  // Ends at a falling edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(negedge aclk);
  endtask
  function automatic logic [15:0] f_view(logic [15:0] l, logic [15:0] d, logic [15:0] p);
    return (d & l) | (~d & p);
  endfunction
  function automatic logic [15:0] f_claim(logic [3:0] cf);
    logic [15:0] m;
    m = {{8{cf[1]}}, {8{cf[0]}}};
    // Combined acks free the receive lines for plain use
    if (cf[0] & cf[2]) begin
      m[ACK_RX_A] = 1'b0;
      m[ACK_RX_B] = 1'b0;
    end
    return m;
  endfunction
  function automatic logic [15:0] f_pin(logic [15:0] l, logic [3:0] cf, logic [15:0] a);
    logic [15:0] o;
    o = l & (a | ~f_claim(cf));
    if (cf[0] & cf[2]) o[3:0] = {l[3], l[2] & a[2] & a[3], l[1], l[0] & a[0] & a[1]};
    return o;
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    irq_req = 2'h0;
    alt = 16'h0;
    ext = 16'h0;
    n_mismatch = 0;
    n_checks = 0;
    k = $urandom(17583);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_DIR, 32'h0, RESP_OKAY);
    rd(OFS_CFG, 32'h0, RESP_OKAY);
    wt(1);
    chk(pin_oe, 16'h0);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      lat = 16'($urandom);
      dir = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : 16'($urandom);
      wr(OFS_DATA, {16'h0, lat}, RESP_OKAY);
      ext <= 16'($urandom);
      wr(OFS_DIR, {16'h0, dir}, RESP_OKAY);
      wt(8);
      chk(pin_oe, dir);
      chk(pin_o & dir, lat & dir);
      rd(OFS_DATA, {16'h0, f_view(lat, dir, ext)}, RESP_OKAY);
      m = 16'($urandom);
      wr(OFS_SET, {16'h0, m}, RESP_OKAY);
      lat = f_view(lat, dir, ext) | m;
      m = 16'($urandom);
      wr(OFS_CLR, {16'h0, m}, RESP_OKAY);
      lat = f_view(lat, dir, ext) & ~m;
      wt(3);
      chk(pin_o & dir, lat & dir);
      wr(OFS_DIR, 32'hffff, RESP_OKAY);
      rd(OFS_DATA, {16'h0, lat}, RESP_OKAY);
    end
    $display("test port data done");
    for (k = 0; k < 4; k++) begin
      c = cl[k];
      lat = c[2] ? 16'hffff : 16'($urandom);
      dir = 16'($urandom);
      wr(OFS_DATA, {16'h0, lat}, RESP_OKAY);
      alt <= 16'($urandom);
      wr(OFS_DIR, {16'h0, dir}, RESP_OKAY);
      wr(OFS_CFG, {28'h0, c}, RESP_OKAY);
      wt(8);
      chk(pin_o, f_pin(lat, c, alt));
      chk(pin_oe, dir);
      chk(alt_in, f_claim(c) & f_view(lat, dir, ext));
    end
    $display("test alternate done");
    wr(OFS_CFG, 32'h0, RESP_OKAY);
    irq_req <= 2'h1;
    wt(3);
    chk(vec_valid, 1'b0);
    wr(OFS_CFG, 32'h8, RESP_OKAY);
    irq_req <= 2'h2;
    wt(3);
    chk(vec_valid, 1'b1);
    chk(vec_data, {VEC_TAG, 6'h0, 2'h2});
    @(posedge aclk);
    irq_req <= 2'h0;
    wt(3);
    chk(vec_valid, 1'b0);
    rd(OFS_VEC, {16'h0, VEC_TAG, 8'h02}, RESP_OKAY);
    $display("test vector done");
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1234, RESP_SLVERR);
    $display("test unmapped done");
    wr(OFS_DIR, 32'hffff, RESP_OKAY);
    wr(OFS_DATA, 32'h0, RESP_OKAY);
    wstrb <= 4'h2;
    wr(OFS_DATA, 32'ha5c3, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFS_DATA, 32'ha500, RESP_OKAY);
    $display("test strobe done");
    wr(OFS_CFG, 32'h3, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wt(1);
    chk(pin_oe, 16'h0);
    chk(pin_o, RST_DATA);
    chk(alt_in, 16'h0);
    rd(OFS_CFG, 32'h0, RESP_OKAY);
    $display("test mid reset done");
    test_done();
  end
endmodule
`default_nettype wire
